// file: common/bcis_defines.svh
// constants for the bus cycle indicator and strobe block
`ifndef BCIS_DEFINES_SVH
`define BCIS_DEFINES_SVH
`define BCIS_BUS_W      32
`define BCIS_CFG_W      4
`define BCIS_CFG_RST    4'h0
`define BCIS_TURN_CYC   1
`endif

// file: common/bcis_pkg.sv
// types for the bus cycle indicator and strobe block
package bcis_pkg;
  typedef enum logic [2:0] {
    BCIS_IDLE,
    BCIS_ADDR,
    BCIS_TURN,
    BCIS_DATA,
    BCIS_DONE
  } bcis_state_t;
endpackage

// file: src/bcis_strobes.sv
// address phase, diagnostic multiplex, latch strobe and memory drive enable
// What this block does
// - diagnostic output means different things per phase
// - address phase: high means cache miss read
// - second slot: high on instruction read, low on data read and on every write
// - latch strobe marks valid address on bus
// - drive enable only after bus released
// - drive enable low on writes and idle
// - shared pins are config inputs during reset
// - 32-bit multiplexed address then data bus
`timescale 1ns/100ps
`include "bcis_defines.svh"
module bcis_strobes
  import bcis_pkg::*;
(
  input  wire logic                    ref_clk,
  input  wire logic                    rst,
  input  wire logic                    req_valid,
  input  wire logic                    req_read,
  input  wire logic                    req_miss,
  input  wire logic                    req_instr,
  input  wire logic [`BCIS_BUS_W-1:0]  req_addr,
  input  wire logic [`BCIS_BUS_W-1:0]  req_wdata,
  input  wire logic                    mem_ack,
  input  wire logic [`BCIS_BUS_W-1:0]  ad_in,
  input  wire logic [`BCIS_CFG_W-1:0]  cfg_pins_in,
  output logic [`BCIS_BUS_W-1:0]       ad_out,
  output logic                         ad_oe,
  output logic                         diag_out,
  output logic                         addr_latch_en,
  output logic                         memory_drive_enable,
  output logic [`BCIS_BUS_W-1:0]       rd_data,
  output logic                         rd_valid,
  output logic                         busy,
  output logic [`BCIS_CFG_W-1:0]       cfg_mode
);

  bcis_state_t                state_q;
  logic                       read_q;
  logic                       miss_q;
  logic                       instr_q;
  logic [`BCIS_BUS_W-1:0]     wdata_q;

  // transaction sequencer; the turn slot gives the bus a dead cycle before memory drives
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state_q <= BCIS_IDLE;
    end else begin
      unique case (state_q)
        BCIS_IDLE: if (req_valid) state_q <= BCIS_ADDR;
        BCIS_ADDR: state_q <= read_q ? BCIS_TURN : BCIS_DATA;
        BCIS_TURN: state_q <= BCIS_DATA;
        BCIS_DATA: if (mem_ack) state_q <= BCIS_DONE;
        BCIS_DONE: state_q <= BCIS_IDLE;
      endcase
    end
  end

  // capture the request attributes at launch
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      read_q  <= 1'b0;
      miss_q  <= 1'b0;
      instr_q <= 1'b0;
      wdata_q <= '0;
    end else if (state_q == BCIS_IDLE && req_valid) begin
      read_q  <= req_read;
      miss_q  <= req_miss;
      instr_q <= req_instr;
      wdata_q <= req_wdata;
    end
  end

  // multiplexed bus drive: address first, write data after, released on reads
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      ad_out <= '0;
      ad_oe  <= 1'b0;
    end else if (state_q == BCIS_IDLE && req_valid) begin
      ad_out <= req_addr;
      ad_oe  <= 1'b1;
    end else if (state_q == BCIS_ADDR) begin
      ad_out <= read_q ? '0 : wdata_q;
      ad_oe  <= ~read_q;
    end else if (state_q == BCIS_DATA && mem_ack) begin
      ad_oe  <= 1'b0;
    end
  end

  // latch strobe lives only while the address is on the bus
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      addr_latch_en <= 1'b0;
    end else begin
      addr_latch_en <= (state_q == BCIS_IDLE) && req_valid;
    end
  end

  // diagnostic: read miss flag in address slot, read instruction flag afterwards (low on writes)
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      diag_out <= 1'b0;
    end else if (state_q == BCIS_IDLE && req_valid) begin
      diag_out <= req_read & req_miss;
    end else if (state_q == BCIS_ADDR) begin
      diag_out <= read_q & instr_q;
    end
  end

  // drive enable follows the bus release on reads only; low on writes and idle
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      memory_drive_enable <= 1'b0;
    end else if (state_q == BCIS_TURN) begin
      memory_drive_enable <= 1'b1;
    end else if (state_q == BCIS_DATA && mem_ack) begin
      memory_drive_enable <= 1'b0;
    end else if (state_q != BCIS_DATA) begin
      memory_drive_enable <= 1'b0;
    end
  end

  // read word taken off the bus at the acknowledge edge, while memory still drives it
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      rd_data  <= '0;
      rd_valid <= 1'b0;
    end else begin
      rd_valid <= (state_q == BCIS_DATA) && mem_ack && read_q;
      if (state_q == BCIS_DATA && mem_ack && read_q) rd_data <= ad_in;
    end
  end

  // busy flag for the requester
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      busy <= 1'b0;
    end else begin
      busy <= (state_q == BCIS_IDLE) ? req_valid : (state_q != BCIS_DONE);
    end
  end

  // configuration pins sampled while reset holds; pins revert afterwards
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      cfg_mode <= cfg_pins_in;
    end
  end

  // assertions
  sequence s_launch;
    (state_q == BCIS_IDLE) && req_valid;
  endsequence

  // read turnaround slot: nobody may drive the wires here
  sequence s_read_turn;
    (state_q == BCIS_TURN);
  endsequence

  // acknowledge seen in the data phase, read or write
  sequence s_data_end;
    (state_q == BCIS_DATA) && mem_ack;
  endsequence

  // acknowledge of a read; the word is on the wires at this edge
  sequence s_read_end;
    (state_q == BCIS_DATA) && mem_ack && read_q;
  endsequence

  // address slot of a write; store data follows on the same wires
  sequence s_write_addr;
    (state_q == BCIS_ADDR) && !read_q;
  endsequence

  AST_STROBE_ONE: assert property (@(posedge ref_clk) disable iff (rst)
    s_launch |=> addr_latch_en ##1 !addr_latch_en)
    else $error("latch strobe not one cycle at launch");
  AST_STROBE_ONLY_ADDR: assert property (@(posedge ref_clk) disable iff (rst)
    addr_latch_en |-> ad_oe && state_q == BCIS_ADDR)
    else $error("latch strobe outside address phase");
  AST_MISS_SLOT: assert property (@(posedge ref_clk) disable iff (rst)
    s_launch |=> diag_out == (read_q & miss_q))
    else $error("miss flag wrong in address slot");
  AST_INSTR_SLOT: assert property (@(posedge ref_clk) disable iff (rst)
    (state_q == BCIS_ADDR) && read_q |=> diag_out == instr_q)
    else $error("instruction flag wrong in second slot");
  AST_PHASE_CHANGE: assert property (@(posedge ref_clk) disable iff (rst)
    s_launch ##1 (read_q && miss_q && !instr_q) |=> !diag_out)
    else $error("diagnostic not multiplexed");
  AST_NO_CONTENTION: assert property (@(posedge ref_clk) disable iff (rst)
    memory_drive_enable |-> !ad_oe && !$past(ad_oe))
    else $error("drive enable while bus driven");
  AST_WRITE_LOW: assert property (@(posedge ref_clk) disable iff (rst)
    memory_drive_enable |-> read_q && state_q == BCIS_DATA)
    else $error("drive enable outside read data phase");
  AST_IDLE_LOW: assert property (@(posedge ref_clk) disable iff (rst)
    state_q == BCIS_IDLE |-> !memory_drive_enable)
    else $error("drive enable while idle");
  AST_ADDR_ON_BUS: assert property (@(posedge ref_clk) disable iff (rst)
    s_launch |=> ad_oe && ad_out == $past(req_addr))
    else $error("address not presented");
  AST_CFG_HOLD: assert property (@(posedge ref_clk) disable iff (rst)
    !$past(rst) |-> $stable(cfg_mode))
    else $error("config mode changed after reset");

  // phase ordering checks; a slip here would put two drivers on the wires
  AST_TURN_RELEASED: assert property (@(posedge ref_clk) disable iff (rst)
    s_read_turn |-> !ad_oe && !memory_drive_enable)
    else $error("bus not released in turnaround slot");
  AST_DRIVE_AFTER_TURN: assert property (@(posedge ref_clk) disable iff (rst)
    s_read_turn |=> memory_drive_enable)
    else $error("drive enable missing after turnaround");
  AST_DRIVE_OFF_ACK: assert property (@(posedge ref_clk) disable iff (rst)
    s_data_end |=> !memory_drive_enable && !ad_oe)
    else $error("bus still driven after acknowledge");
  AST_WRITE_DATA: assert property (@(posedge ref_clk) disable iff (rst)
    s_write_addr |=> ad_oe && !memory_drive_enable && ad_out == wdata_q)
    else $error("write data not on bus after address");
  AST_READ_DATA: assert property (@(posedge ref_clk) disable iff (rst)
    s_read_end |=> rd_valid && rd_data == $past(ad_in))
    else $error("read word not captured at acknowledge");
  AST_NO_RELAUNCH: assert property (@(posedge ref_clk) disable iff (rst)
    state_q != BCIS_IDLE |=> !addr_latch_en)
    else $error("latch strobe while a transfer is running");

endmodule // bcis_strobes

// file: sim/bcis_mem_model.sv
// external memory model facing the strobe block
`timescale 1ns/100ps
`include "bcis_defines.svh"
module bcis_mem_model (
  input  wire logic                   ref_clk,
  input  wire logic                   rst,
  input  wire logic [3:0]             wait_cyc,
  input  wire logic [`BCIS_BUS_W-1:0] ad_out,
  input  wire logic                   ad_oe,
  input  wire logic                   addr_latch_en,
  input  wire logic                   memory_drive_enable,
  output logic                        mem_ack,
  output logic [`BCIS_BUS_W-1:0]      ad_in,
  output logic [`BCIS_BUS_W-1:0]      wr_q
);
  logic [`BCIS_BUS_W-1:0] addr_q;
  logic [`BCIS_BUS_W-1:0] last_q;
  logic [3:0]             cnt_q;
  // latch address on the strobe, ack once after wait_cyc cycles
  always_ff @(posedge ref_clk) begin
    if (addr_latch_en) addr_q <= ad_out;
    if (rst || addr_latch_en || cnt_q == wait_cyc || cnt_q == 4'h0) cnt_q <= addr_latch_en ? 4'h1 : 4'h0;
    else cnt_q <= cnt_q + 4'h1;
    mem_ack <= !rst && cnt_q != 4'h0 && cnt_q == wait_cyc;
    if (mem_ack && ad_oe) wr_q <= ad_out;
    last_q <= rst ? 32'h0 : ad_in;
  end
  // undriven bus toggles so stale data never looks valid
  assign ad_in = memory_drive_enable ? (addr_q ^ 32'h5a5a_5a5a) : ~last_q;
endmodule // bcis_mem_model

// file: sim/bcis_strobes_tb.sv
// self-checking bench for the strobe block
`timescale 1ns/100ps
module bcis_strobes_tb;
  typedef struct packed {logic rd; logic miss; logic ins; logic [31:0] addr; logic [31:0] wd; logic [3:0] w;} bcis_row_t;
  bcis_row_t   rows [5];
  logic        ref_clk = 0, rst = 1, req_valid = 0, req_read = 0, req_miss = 0, req_instr = 0;
  logic [31:0] req_addr = 0, req_wdata = 0, ad_in, ad_out, rd_data, wr_q;
  logic [3:0]  cfg_pins_in = 4'ha, wait_cyc = 4'h2, cfg_mode;
  logic        mem_ack, ad_oe, diag_out, addr_latch_en, memory_drive_enable, rd_valid, busy, got, drv_seen;
  int          num_errors = 0, cmp_count = 0, cyc = 0, n, strobe_cnt;
  always #12.5 ref_clk = ~ref_clk;
  bcis_strobes uut (.ref_clk, .rst, .req_valid, .req_read, .req_miss, .req_instr, .req_addr, .req_wdata, .mem_ack,
    .ad_in, .cfg_pins_in, .ad_out, .ad_oe, .diag_out, .addr_latch_en, .memory_drive_enable, .rd_data, .rd_valid,
    .busy, .cfg_mode);
  bcis_mem_model mem (.ref_clk, .rst, .wait_cyc, .ad_out, .ad_oe, .addr_latch_en, .memory_drive_enable, .mem_ack,
    .ad_in, .wr_q);
  task chk_bit(input logic got_v, input logic exp_v);
    cmp_count++;
    if (got_v !== exp_v) begin
      num_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got_v, exp_v);
    end
  endtask
  task chk_word(input logic [31:0] got_v, input logic [31:0] exp_v);
    cmp_count++;
    if (got_v !== exp_v) begin
      num_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got_v, exp_v);
    end
  endtask
  task step;
    @(posedge ref_clk);
    #1;
  endtask
  task complete_run;
    $display("compares=%0d mismatches=%0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // one transfer: request for a single edge, then follow it cycle by cycle until busy falls
  task run_row(input bcis_row_t row);
    @(posedge ref_clk);
    req_valid <= 1'b1;
    {req_read, req_miss, req_instr, req_addr, req_wdata, wait_cyc} <= row;
    @(posedge ref_clk);
    req_valid <= 1'b0;
    #1;
    chk_bit(addr_latch_en, 1'b1);
    chk_bit(ad_oe, 1'b1);
    chk_word(ad_out, row.addr);
    chk_bit(busy, 1'b1);
    if (row.rd) chk_bit(diag_out, row.miss);
    step;
    chk_bit(addr_latch_en, 1'b0);
    chk_bit(ad_oe, ~row.rd);
    if (!row.rd) chk_word(ad_out, row.wd);
    chk_bit(diag_out, row.rd & row.ins);
    got = 1'b0;
    drv_seen = 1'b0;
    for (n = 0; n < 40 && busy === 1'b1; n++) begin
      if (n < 2) chk_bit(memory_drive_enable, row.rd && n == 1);
      if (memory_drive_enable === 1'b1) begin
        drv_seen = 1'b1;
        chk_bit(ad_oe, 1'b0);
      end
      chk_bit(memory_drive_enable & ~row.rd, 1'b0);
      if (rd_valid === 1'b1) begin
        got = 1'b1;
        chk_word(rd_data, row.addr ^ 32'h5a5a_5a5a);
      end
      step;
    end
    chk_bit(busy, 1'b0);
    chk_bit(got, row.rd);
    chk_bit(drv_seen, row.rd);
    if (!row.rd) chk_word(wr_q, row.wd);
    chk_bit(memory_drive_enable, 1'b0);
    chk_bit(ad_oe, 1'b0);
  endtask
  // hang guard, far above the roughly 70 cycles the tests need
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 1000) begin
      num_errors++;
      complete_run;
    end
  end
  initial begin
    rows[0] = {3'b111, 32'h1000_0040, 32'h0, 4'h2};
    rows[1] = {3'b100, 32'h2000_0104, 32'h0, 4'h5};
    rows[2] = {3'b000, 32'h3000_0008, 32'hdead_beef, 4'h3};
    rows[3] = {3'b110, 32'hffff_fffc, 32'h0, 4'h2};
    rows[4] = {3'b011, 32'h0000_0000, 32'h0123_4567, 4'h2};
    repeat (9) step;
    chk_word({28'h0, cfg_mode}, 32'h0000_000a);
    chk_bit(memory_drive_enable, 1'b0);
    @(posedge ref_clk);
    rst <= 1'b0;
    cfg_pins_in <= 4'h5;
    // rows back to back: each request follows the fall of busy
    foreach (rows[i]) run_row(rows[i]);
    chk_word({28'h0, cfg_mode}, 32'h0000_000a);
    // a request left high across a whole read must start it only once
    @(posedge ref_clk);
    req_valid <= 1'b1;
    {req_read, req_miss, req_instr, req_addr, wait_cyc} <= {3'b100, 32'h5000_0020, 4'h2};
    strobe_cnt = 0;
    for (n = 0; n < 8; n++) begin
      @(posedge ref_clk);
      if (n == 4) req_valid <= 1'b0;
      #1;
      if (addr_latch_en === 1'b1) strobe_cnt++;
    end
    chk_word(strobe_cnt, 32'h0000_0001);
    chk_bit(busy, 1'b0);
    // reset cutting into a read data phase, with new values on the shared pins
    @(posedge ref_clk);
    req_valid <= 1'b1;
    {req_read, req_miss, req_instr, req_addr, wait_cyc} <= {3'b101, 32'h4000_0010, 4'h8};
    @(posedge ref_clk);
    req_valid <= 1'b0;
    repeat (2) @(posedge ref_clk);
    rst <= 1'b1;
    cfg_pins_in <= 4'h3;
    #1;
    chk_bit(memory_drive_enable, 1'b1);
    step;
    chk_bit(memory_drive_enable, 1'b0);
    chk_bit(ad_oe, 1'b0);
    chk_bit(busy, 1'b0);
    chk_word({28'h0, cfg_mode}, 32'h0000_0003);
    @(posedge ref_clk);
    rst <= 1'b0;
    cfg_pins_in <= 4'hc;
    run_row(rows[3]);
    chk_word({28'h0, cfg_mode}, 32'h0000_0003);
    complete_run;
  end
endmodule // bcis_strobes_tb
